// ===== design/ecsp_pkg.sv
// Types shared by the serial configuration port design.
package ecsp_pkg;

    // ======================================================================
    // Types
    // ======================================================================
    typedef logic [3:0] ecsp_addr_t;   // Register address.
    typedef logic [15:0] ecsp_word_t;  // Register value.
    typedef logic [8:0] ecsp_adj_t;    // Nine-bit trim code (512 steps).

    // Receiver frame state.
    typedef enum logic [0:0]
    {
        ECSP_IDLE = 1'b0,
        ECSP_SHIFT = 1'b1
    } ecsp_frame_state_t;

endpackage : ecsp_pkg

// ===== design/ecsp_port.sv
// Extended control serial port: mode selection, frame receiver and write-only register bank.
`include "ecsp_regs.svh"

module ecsp_port
(
    input wire logic clk,                            // System clock, 10 MHz.
    input wire logic rst_n,                          // Synchronous reset, active low.
    input wire logic ext_ctrl_strap,                 // High when the mode pin selects extended control.
    input wire logic range_or_ext_ctrl_select,       // Normal mode range level: high selects the wide range.
    input wire logic rate_pin,                       // Normal mode: high selects double rate.
    input wire logic edge_pin,                       // Normal mode: high means data changes on rising edge.
    input wire logic level_pin,                      // Normal mode: high selects normal amplitude.
    input wire logic cal_des_pin,                    // Normal mode: long calibration delay and dual-edge enable.
    input wire logic sclk,                           // Serial clock from the host.
    input wire logic serial_select_n,                // Serial select, active low.
    input wire logic serial_data_in,                 // Serial data, MSB first.
    output logic ddr_mode,                           // Double-rate output clocking in force.
    output logic ddr_phase_90,                       // Double-rate clock placed mid bit-cell.
    output logic sdr_rise_edge,                      // Single-rate data changes on rising clock edge.
    output logic level_normal,                       // Normal output amplitude in force.
    output logic cal_delay_long,                     // Long power-on calibration delay in force.
    output logic range_wide,                         // Normal mode wide range selected for both channels.
    output logic adjust_enable,                      // Full-scale and offset trims in force.
    output ecsp_pkg::ecsp_adj_t full_scale_i,        // I channel full-scale trim.
    output ecsp_pkg::ecsp_adj_t full_scale_q,        // Q channel full-scale trim.
    output ecsp_pkg::ecsp_adj_t offset_i,            // I channel offset trim.
    output ecsp_pkg::ecsp_adj_t offset_q,            // Q channel offset trim.
    output logic dual_edge_enable,                   // Dual-edge sampling in force.
    output logic dual_edge_q_select,                 // Dual-edge sampling takes the Q input.
    output logic dual_edge_auto_phase,               // Automatic dual-edge clock phase control.
    output ecsp_pkg::ecsp_word_t dual_edge_coarse,   // Manual coarse phase value.
    output ecsp_pkg::ecsp_word_t dual_edge_fine,     // Manual fine phase value.
    output logic write_pulse,                        // One-cycle pulse when a valid frame lands.
    output logic frame_error                         // One-cycle pulse when a frame header is wrong.
);
    import ecsp_pkg::*;

    // ======================================================================
    // Input synchronisers
    // ======================================================================
    logic [1:0] sclk_sync;    // Serial clock chain.
    logic [1:0] sel_sync;     // Select chain.
    logic [1:0] data_sync;    // Data chain.
    logic [1:0] mode_sync;    // Mode strap chain.
    logic [4:0] pin_sync1;    // First stage of the static pins.
    logic [4:0] pin_sync2;    // Second stage of the static pins.
    logic sclk_prev;          // Delayed synced clock for edge finding.
    logic ext_mode;           // Extended control mode is selected.
    logic sclk_rise;          // One-cycle mark of a serial clock rise.

    // Every pin crosses two flops; only the second stage and its sclk_prev copy feed logic.
    always_ff @(posedge clk)
    begin
        sclk_sync <= {sclk_sync[0], sclk};
        sel_sync <= {sel_sync[0], serial_select_n};
        data_sync <= {data_sync[0], serial_data_in};
        mode_sync <= {mode_sync[0], ext_ctrl_strap};
        pin_sync1 <= {range_or_ext_ctrl_select, rate_pin, edge_pin, level_pin, cal_des_pin};
        pin_sync2 <= pin_sync1;
        sclk_prev <= sclk_sync[1];
    end

    assign ext_mode = mode_sync[1];
    assign sclk_rise = sclk_sync[1] & ~sclk_prev;

    // ======================================================================
    // Frame receiver
    // ======================================================================
    ecsp_frame_state_t state;     // Receiver state.
    logic [4:0] bit_count;        // Bits taken so far in this frame.
    logic [31:0] shift;           // Incoming frame, MSB first.
    logic [31:0] frame;           // Complete frame including the last bit.
    logic frame_done;             // The 32nd bit arrives this cycle.
    logic header_ok;              // Complete frame carries the fixed header.
    ecsp_addr_t frame_addr;       // Address field of the complete frame.

    assign frame = {shift[30:0], data_sync[1]};
    assign frame_done = (state == ECSP_SHIFT) && sclk_rise && !sel_sync[1] && (bit_count == `ECSP_LAST_BIT);
    assign header_ok = (frame[`ECSP_HDR_MSB:`ECSP_HDR_LSB] == `ECSP_HEADER);
    assign frame_addr = frame[`ECSP_ADR_MSB:`ECSP_ADR_LSB];

    // Shift on each serial clock rise while selected; select high resynchronises.
    // Normal mode holds the receiver idle so pin noise cannot reach the bank.
    always_ff @(posedge clk)
    begin
        if (!rst_n || !ext_mode)
        begin
            state <= ECSP_IDLE;
            bit_count <= 5'd0;
            shift <= 32'h0000_0000;
        end
        else
        begin
            case (state)
                ECSP_IDLE:
                begin
                    // Wait for select; the first rise is taken in the next state.
                    bit_count <= 5'd0;
                    if (!sel_sync[1])
                    begin
                        state <= ECSP_SHIFT;
                    end
                end
                ECSP_SHIFT:
                begin
                    if (sel_sync[1])
                    begin
                        state <= ECSP_IDLE;
                        bit_count <= 5'd0;
                    end
                    else if (sclk_rise)
                    begin
                        // Count wraps after 32 bits so the next frame starts at once.
                        shift <= frame;
                        bit_count <= bit_count + 5'd1;
                    end
                end
                default:
                begin
                    state <= ECSP_IDLE;
                end
            endcase
        end
    end

    // ======================================================================
    // Register bank (write-only, eight entries)
    // ======================================================================
    localparam int NREG = 8;
    localparam logic [NREG*4-1:0] REG_ADDRS = {`ECSP_ADDR_DES_FINE, `ECSP_ADDR_DES_COARSE,
        `ECSP_ADDR_DES_ENABLE, `ECSP_ADDR_Q_FULL_SCALE, `ECSP_ADDR_Q_OFFSET,
        `ECSP_ADDR_I_FULL_SCALE, `ECSP_ADDR_I_OFFSET, `ECSP_ADDR_CONFIG};
    localparam logic [NREG*16-1:0] REG_RESETS = {`ECSP_RST_DES_ADJ, `ECSP_RST_DES_ADJ,
        `ECSP_RST_DES_ENABLE, `ECSP_RST_FULL_SCALE, `ECSP_RST_OFFSET,
        `ECSP_RST_FULL_SCALE, `ECSP_RST_OFFSET, `ECSP_RST_CONFIG};

    ecsp_word_t regs [NREG];  // Bank; there is deliberately no path that reads it back out.
    logic [NREG-1:0] hit;     // Per-entry address match.

    // One entry per register; addresses with no entry match nothing and are dropped.
    genvar k;
    generate
        for (k = 0; k < NREG; k++)
        begin : g_reg
            assign hit[k] = (frame_addr == REG_ADDRS[k*4 +: 4]);
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    regs[k] <= REG_RESETS[k*16 +: 16];
                end
                else if (frame_done && header_ok && hit[k])
                begin
                    regs[k] <= frame[15:0];
                end
            end
        end
    endgenerate

    // Status pulses for a landed frame or a rejected header.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            write_pulse <= 1'b0;
            frame_error <= 1'b0;
        end
        else
        begin
            write_pulse <= frame_done && header_ok;
            frame_error <= frame_done && !header_ok;
        end
    end

    // ======================================================================
    // Effective settings
    // ======================================================================
    ecsp_word_t cfg;  // Configuration register.
    ecsp_word_t des;  // Dual-edge enable register.
    assign cfg = regs[0];
    assign des = regs[5];

    // Rate, edge, level and dual-edge enable come from a pin in normal mode and a register bit in extended mode.
    // The registers keep their values in normal mode but steer nothing there.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ddr_mode <= 1'b0;
            ddr_phase_90 <= 1'b0;
            sdr_rise_edge <= 1'b0;
            level_normal <= 1'b0;
            cal_delay_long <= 1'b0;
            range_wide <= 1'b0;
            dual_edge_enable <= 1'b0;
            dual_edge_q_select <= 1'b0;
        end
        else if (ext_mode)
        begin
            ddr_mode <= !cfg[`ECSP_CFG_RATE_N];
            ddr_phase_90 <= cfg[`ECSP_CFG_PHASE];
            sdr_rise_edge <= cfg[`ECSP_CFG_EDGE];
            level_normal <= cfg[`ECSP_CFG_LEVEL];
            cal_delay_long <= 1'b0;
            range_wide <= 1'b0;
            dual_edge_enable <= des[`ECSP_DES_EN];
            dual_edge_q_select <= des[`ECSP_DES_QSEL];
        end
        else
        begin
            ddr_mode <= pin_sync2[3];
            ddr_phase_90 <= 1'b0;
            sdr_rise_edge <= pin_sync2[2];
            level_normal <= pin_sync2[1];
            cal_delay_long <= pin_sync2[0];
            range_wide <= pin_sync2[4];
            dual_edge_enable <= pin_sync2[0];
            dual_edge_q_select <= 1'b0;
        end
    end

    // Trim and phase values; zeroed in normal mode where trims do not exist.
    always_ff @(posedge clk)
    begin
        if (!rst_n || !ext_mode)
        begin
            adjust_enable <= 1'b0;
            full_scale_i <= 9'h000;
            full_scale_q <= 9'h000;
            offset_i <= 9'h000;
            offset_q <= 9'h000;
            dual_edge_auto_phase <= 1'b0;
            dual_edge_coarse <= 16'h0000;
            dual_edge_fine <= 16'h0000;
        end
        else
        begin
            adjust_enable <= 1'b1;
            full_scale_i <= regs[2][`ECSP_ADJ_MSB:`ECSP_ADJ_LSB];
            full_scale_q <= regs[4][`ECSP_ADJ_MSB:`ECSP_ADJ_LSB];
            offset_i <= regs[1][`ECSP_ADJ_MSB:`ECSP_ADJ_LSB];
            offset_q <= regs[3][`ECSP_ADJ_MSB:`ECSP_ADJ_LSB];
            dual_edge_auto_phase <= des[`ECSP_DES_AUTO];
            dual_edge_coarse <= regs[6];
            dual_edge_fine <= regs[7];
        end
    end

    // ======================================================================
    // Assertions
    // ======================================================================
    property p_normal_idle;
        @(posedge clk) disable iff (!rst_n) !ext_mode |=> (state == ECSP_IDLE) && (bit_count == 5'd0);
    endproperty
    a_normal_idle: assert property (p_normal_idle) else $error("receiver active in normal mode");

    property p_rate_source;
        // The antecedent skips the release edge, where the output still holds its reset value.
        @(posedge clk) disable iff (!rst_n)
            rst_n |=> ddr_mode == ($past(ext_mode) ? !$past(cfg[`ECSP_CFG_RATE_N]) : $past(pin_sync2[3]));
    endproperty
    a_rate_source: assert property (p_rate_source) else $error("rate select from wrong source");

    property p_phase_normal;
        @(posedge clk) disable iff (!rst_n) !ext_mode |=> !ddr_phase_90;
    endproperty
    a_phase_normal: assert property (p_phase_normal) else $error("phase not zero in normal mode");

    property p_short_delay;
        @(posedge clk) disable iff (!rst_n) ext_mode ##1 ext_mode |-> !cal_delay_long;
    endproperty
    a_short_delay: assert property (p_short_delay) else $error("long delay in extended mode");

    property p_no_offset_normal;
        @(posedge clk) disable iff (!rst_n) !ext_mode |=> !adjust_enable && (offset_i == 9'h000);
    endproperty
    a_no_offset_normal: assert property (p_no_offset_normal) else $error("offset active in normal mode");

    property p_write_cause;
        @(posedge clk) disable iff (!rst_n) write_pulse |-> $past(frame_done) && $past(header_ok);
    endproperty
    a_write_cause: assert property (p_write_cause) else $error("write without valid frame");

    property p_frame_length;
        @(posedge clk) disable iff (!rst_n) frame_done |=> (bit_count == 5'd0);
    endproperty
    a_frame_length: assert property (p_frame_length) else $error("frame length not 32");

    property p_reserved_drop;
        @(posedge clk) disable iff (!rst_n) (frame_done && hit == '0) |=> $stable(cfg) && $stable(des);
    endproperty
    a_reserved_drop: assert property (p_reserved_drop) else $error("reserved write changed bank");

    property p_reset_defaults;
        @(posedge clk) !rst_n |=> (cfg == `ECSP_RST_CONFIG) && (des == `ECSP_RST_DES_ENABLE);
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("bad power-on defaults");

    c_good_frame: cover property (@(posedge clk) disable iff (!rst_n) write_pulse);
    c_bad_header: cover property (@(posedge clk) disable iff (!rst_n) frame_error);
    c_back_to_back: cover property (@(posedge clk) disable iff (!rst_n)
        write_pulse ##[1:300] write_pulse);
    c_des_on: cover property (@(posedge clk) disable iff (!rst_n) ext_mode && dual_edge_enable);

endmodule : ecsp_port

// ===== design/ecsp_regs.svh
// Register offsets, field positions, reset values and frame constants of the serial configuration port.
`ifndef ECSP_REGS_SVH
`define ECSP_REGS_SVH

// ==========================================================================
// Frame layout
// ==========================================================================
`define ECSP_FRAME_BITS 6'd32
`define ECSP_LAST_BIT 5'd31
`define ECSP_HEADER 12'h001
`define ECSP_HDR_MSB 31
`define ECSP_HDR_LSB 20
`define ECSP_ADR_MSB 19
`define ECSP_ADR_LSB 16

// ==========================================================================
// Register offsets (4-bit addresses)
// ==========================================================================
`define ECSP_ADDR_CONFIG 4'h1
`define ECSP_ADDR_I_OFFSET 4'h2
`define ECSP_ADDR_I_FULL_SCALE 4'h3
`define ECSP_ADDR_Q_OFFSET 4'ha
`define ECSP_ADDR_Q_FULL_SCALE 4'hb
`define ECSP_ADDR_DES_ENABLE 4'hd
`define ECSP_ADDR_DES_COARSE 4'he
`define ECSP_ADDR_DES_FINE 4'hf

// ==========================================================================
// Field positions
// ==========================================================================
`define ECSP_CFG_PHASE 11
`define ECSP_CFG_RATE_N 10
`define ECSP_CFG_LEVEL 9
`define ECSP_CFG_EDGE 8
`define ECSP_ADJ_MSB 15
`define ECSP_ADJ_LSB 7
`define ECSP_DES_EN 15
`define ECSP_DES_AUTO 14
`define ECSP_DES_QSEL 13

// ==========================================================================
// Reset values
// ==========================================================================
`define ECSP_RST_CONFIG 16'hb2ff
`define ECSP_RST_OFFSET 16'h0000
`define ECSP_RST_FULL_SCALE 16'h8000
`define ECSP_RST_DES_ENABLE 16'h3fff
`define ECSP_RST_DES_ADJ 16'h0000

`endif

// ===== tb/ecsp_host_model.sv
// Host controller model that drives the three-wire serial configuration link.
module ecsp_host_model
(
    input wire logic clk,     // Bench clock that paces every pin change.
    output logic sclk,        // Serial clock, parked low while select is high.
    output logic serial_select_n, // Select, active low.
    output logic serial_data_in   // Serial data, most significant bit first.
);
    timeunit 1ns;
    timeprecision 1ns;

    // ======================================================================
    // Idle state
    // ======================================================================
    // The link clock stands still outside frames, so it starts low.
    initial
    begin
        sclk = 1'b0;
        serial_select_n = 1'b1;
        serial_data_in = 1'b0;
    end

    // ======================================================================
    // Frame transmission
    // ======================================================================
    // Shifts the first n bits of w, 400 ns low and 400 ns high per bit.
    // Data changes only while sclk is low, so it is stable at each rise.
    // The bench never starts a calibration, so no frame overlaps one.
    task frame(input logic [31:0] w, input int n, input bit last);
        if (serial_select_n)
        begin
            @(posedge clk);
            serial_select_n <= 1'b0;
            repeat (10) @(posedge clk);        // More than 1 us of setup before the first rise.
        end
        for (int i = 0; i < n; i++)
        begin
            sclk <= 1'b0;
            serial_data_in <= w[31 - i];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
        end
        // Without last, select stays low and the next frame starts at rise 33.
        if (last)
        begin
            sclk <= 1'b0;
            repeat (4) @(posedge clk);
            serial_select_n <= 1'b1;
            serial_data_in <= ~serial_data_in; // A released line keeps no old value.
            repeat (4) @(posedge clk);
        end
    endtask : frame
endmodule : ecsp_host_model

// ===== tb/tb_top.sv
// Self-checking bench of the serial configuration port with a host model on the far side.
`include "ecsp_regs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import ecsp_pkg::*;

    // ======================================================================
    // Signals
    // ======================================================================
    logic clk, rst_n, ext_ctrl_strap, range_sel, rate_pin, edge_pin, level_pin, cal_des_pin;
    logic sclk, serial_select_n, serial_data_in;
    logic ddr_mode, ddr_phase_90, sdr_rise_edge, level_normal, cal_delay_long, range_wide, adjust_enable;
    logic dual_edge_enable, dual_edge_q_select, dual_edge_auto_phase, write_pulse, frame_error;
    ecsp_adj_t full_scale_i, full_scale_q, offset_i, offset_q;
    ecsp_word_t dual_edge_coarse, dual_edge_fine;
    ecsp_word_t e_cfg, e_oi, e_fi, e_oq, e_fq, e_des, e_crs, e_fin; // Expected register contents.
    logic [1:0] pend[$];   // Expected events, frame_error then write_pulse.
    logic [15:0] rnd;      // Random source state.
    logic [4:0] p;         // Last pin pattern driven.
    int num_errors, check_count;
    ecsp_addr_t adr[7] = '{4'h1, 4'h2, 4'h3, 4'ha, 4'hb, 4'he, 4'hf};
    ecsp_addr_t rsv[8] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hc};

    // ======================================================================
    // Design and far side
    // ======================================================================
    ecsp_port ecsp_port_inst (.clk(clk), .rst_n(rst_n), .ext_ctrl_strap(ext_ctrl_strap),
        .range_or_ext_ctrl_select(range_sel), .rate_pin(rate_pin), .edge_pin(edge_pin), .level_pin(level_pin),
        .cal_des_pin(cal_des_pin), .sclk(sclk), .serial_select_n(serial_select_n),
        .serial_data_in(serial_data_in), .ddr_mode(ddr_mode), .ddr_phase_90(ddr_phase_90),
        .sdr_rise_edge(sdr_rise_edge), .level_normal(level_normal), .cal_delay_long(cal_delay_long),
        .range_wide(range_wide), .adjust_enable(adjust_enable), .full_scale_i(full_scale_i),
        .full_scale_q(full_scale_q), .offset_i(offset_i), .offset_q(offset_q),
        .dual_edge_enable(dual_edge_enable), .dual_edge_q_select(dual_edge_q_select),
        .dual_edge_auto_phase(dual_edge_auto_phase), .dual_edge_coarse(dual_edge_coarse),
        .dual_edge_fine(dual_edge_fine), .write_pulse(write_pulse), .frame_error(frame_error));
    ecsp_host_model ecsp_host_model_inst (.clk(clk), .sclk(sclk), .serial_select_n(serial_select_n),
        .serial_data_in(serial_data_in));

    // ======================================================================
    // Clock, watchdog and helpers
    // ======================================================================
    // The 10 MHz clock inverts every half period.
    always #50 clk = ~clk;

    // A hang counts as a mismatch and ends the run.
    initial
    begin
        repeat (100000) @(posedge clk);
        num_errors++;
        test_done();
    end

    // Compares one value and counts the result.
    task check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Advances the feedback register and puts a fresh pattern on the mode pins.
    task pins_rand();
        rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
        p = rnd[4:0];
        @(posedge clk);
        {range_sel, rate_pin, edge_pin, level_pin, cal_des_pin} <= p;
    endtask : pins_rand

    // Sends one good frame and notes its effect on the expected registers.
    task wr(input ecsp_addr_t a, input ecsp_word_t d, input bit last);
        pend.push_back(2'b01);
        case (a)
            4'h1: e_cfg = d;
            4'h2: e_oi = d;
            4'h3: e_fi = d;
            4'ha: e_oq = d;
            4'hb: e_fq = d;
            4'hd: e_des = d;
            4'he: e_crs = d;
            4'hf: e_fin = d;
            default: ;                        // Reserved places keep every register.
        endcase
        ecsp_host_model_inst.frame({`ECSP_HEADER, a, d}, 32, last);
    endtask : wr

    // Compares every extended-mode output with the expected registers, ddr_phase_90 only at double rate; pins must not matter.
    task check_ext();
        repeat (4) @(posedge clk);
        check(16'(ddr_mode), 16'(!e_cfg[10]));
        if (!e_cfg[10]) check(16'(ddr_phase_90), 16'(e_cfg[11]));
        check(16'(sdr_rise_edge), 16'(e_cfg[8]));
        check(16'(level_normal), 16'(e_cfg[9]));
        check(16'(cal_delay_long), 16'h0);
        check(16'(adjust_enable), 16'h1);
        check(16'(range_wide), 16'h0);
        check(16'(full_scale_i), 16'(e_fi[15:7]));
        check(16'(full_scale_q), 16'(e_fq[15:7]));
        check(16'(offset_i), 16'(e_oi[15:7]));
        check(16'(offset_q), 16'(e_oq[15:7]));
        check(16'({dual_edge_enable, dual_edge_q_select}), 16'({e_des[15], e_des[13]}));
        check(16'(dual_edge_auto_phase), 16'(e_des[14]));
        check(dual_edge_coarse, e_crs);
        check(dual_edge_fine, e_fin);
        check(16'(pend.size()), 16'h0);
    endtask : check_ext

    // ======================================================================
    // Result monitor
    // ======================================================================
    // Each pulse takes the oldest note; a pulse with no note is a mismatch.
    always @(posedge clk)
    begin
        if (write_pulse === 1'b1 || frame_error === 1'b1)
        begin
            check(16'({frame_error, write_pulse}), 16'(pend.size() ? pend.pop_front() : 2'b00));
        end
    end

    // ======================================================================
    // Verdict
    // ======================================================================
    task test_done();
        $display("checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    // ======================================================================
    // Main sequence
    // ======================================================================
    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        ext_ctrl_strap = 1'b1;                 // Fixed before operation.
        {range_sel, rate_pin, edge_pin, level_pin, cal_des_pin} = 5'h00;
        rnd = 16'd22936;
        num_errors = 0;
        check_count = 0;
        {e_cfg, e_oi, e_fi, e_oq, e_fq} = {16'hb2ff, 16'h0000, 16'h8000, 16'h0000, 16'h8000};
        {e_des, e_crs, e_fin} = {16'h3fff, 16'h0000, 16'h0000};
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check_ext();                           // Power-on defaults.
        // Three full loading passes with random values, the frames of each pass back to back.
        for (int n = 0; n < 3; n++)
        begin
            pins_rand();
            wr(4'hd, 16'h3fff, 1'b0);          // Dual-edge off before the config write.
            for (int k = 0; k < 7; k++)
            begin
                pins_rand();
                wr(adr[k], (k == 0) ? {4'hb, rnd[3:0], 8'hff} : rnd, k == 6);
            end
            check_ext();
        end
        // Reserved addresses are answered but change nothing.
        foreach (rsv[k])
        begin
            pins_rand();
            wr(rsv[k], rnd, k == 7);
        end
        check_ext();
        // A wrong header, then a frame cut short, then a good frame after resync.
        pend.push_back(2'b10);
        ecsp_host_model_inst.frame({12'h002, 4'h2, 16'h1234}, 32, 1'b1);
        ecsp_host_model_inst.frame({`ECSP_HEADER, 4'h3, 16'hffff}, 20, 1'b1);
        wr(4'h2, 16'h5a80, 1'b1);
        check_ext();
        // Dual-edge sampling switched on last, with random phase and channel choices.
        wr(4'hd, {1'b1, rnd[2:1], 13'h0}, 1'b1);
        check_ext();
        // Normal mode after a fresh power-up: pins rule and the port is ignored.
        ext_ctrl_strap <= 1'b0;
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (int n = 0; n < 4; n++)
        begin
            pins_rand();
            ecsp_host_model_inst.frame({`ECSP_HEADER, 4'h2, rnd}, 32, 1'b1);
            check(16'({ddr_mode, sdr_rise_edge, level_normal}), 16'(p[3:1]));
            check(16'({cal_delay_long, dual_edge_enable, range_wide}), 16'({p[0], p[0], p[4]}));
            check(16'({ddr_phase_90, dual_edge_q_select, adjust_enable}), 16'h0);
            check(16'(offset_i), 16'h0);
        end
        test_done();
    end
endmodule : tb_top
